// ---- hbas_params.svh ----
// Constants shared by the host bus address select ends.
// Assumes inclusion by bare name from package and modules.
`ifndef HBAS_PARAMS_SVH
`define HBAS_PARAMS_SVH
`define HBAS_DATA_W 8
`define HBAS_FIFO_DEPTH 16
`define HBAS_PTR_W 4
`define HBAS_RST_CYCLES 4'h8
`define HBAS_IDLE_CHAR 8'hbc
`define HBAS_CTRL_RESET 8'h01
`define HBAS_REG_CTRL 4'h0
`define HBAS_REG_STAT 4'h1
`define HBAS_REG_TXD 4'h2
`define HBAS_REG_RXD 4'h3
`define HBAS_BIT_BYP 0
`define HBAS_BIT_CAS 1
`define HBAS_BIT_AM 2
`define HBAS_BIT_TRANSMIT_FIFO_RESET_N 3
`define HBAS_BIT_RECEIVE_FIFO_RESET_N 4
`define HBAS_BIT_TXGO 0
`define HBAS_BIT_RXGO 1
`endif

// ---- hbas_pkg.sv ----
// Types for the host bus address select ends.
// Assumes hbas_params.svh is on the include path.
`include "hbas_params.svh"
package hbas_pkg;
  typedef enum logic {HBAS_UTOPIA, HBAS_CASCADE} hbas_model_t;
  typedef logic [`HBAS_DATA_W-1:0] hbas_byte_t;
endpackage : hbas_pkg

// ---- hbas_if.sv ----
// Parallel host bus between the transceiver and its host.
// Assumes one shared clock; flag pins resolved by the testbench.
`timescale 1ns/10ps
`default_nettype none
interface hbas_if;
  logic address_match_n;
  logic transmit_write_enable;
  logic receive_read_enable;
  logic transmit_fifo_reset_n;
  logic receive_fifo_reset_n;
  logic fifo_bypass_n;
  logic timing_model_select;
  hbas_pkg::hbas_byte_t transmit_data_bus;
  hbas_pkg::hbas_byte_t receive_data_bus;
  logic receive_data_oe;
  logic transmit_full_flag;
  logic transmit_empty_flag;
  logic transmit_flag_oe;
  logic receive_full_flag;
  logic receive_empty_flag;
  logic receive_flag_oe;
  modport dev (
    input address_match_n, transmit_write_enable, receive_read_enable,
    input transmit_fifo_reset_n, receive_fifo_reset_n, fifo_bypass_n,
    input timing_model_select, transmit_data_bus,
    output receive_data_bus, receive_data_oe, transmit_full_flag,
    output transmit_empty_flag, transmit_flag_oe, receive_full_flag,
    output receive_empty_flag, receive_flag_oe
  );
  modport host (
    output address_match_n, transmit_write_enable, receive_read_enable,
    output transmit_fifo_reset_n, receive_fifo_reset_n, fifo_bypass_n,
    output timing_model_select, transmit_data_bus,
    input receive_data_bus, receive_data_oe, transmit_full_flag,
    input transmit_empty_flag, transmit_flag_oe, receive_full_flag,
    input receive_empty_flag, receive_flag_oe
  );
endinterface : hbas_if
`default_nettype wire

// ---- hbas_dev.sv ----
// Device end: address match, selection, FIFO reset and flag drivers.
// Assumes one 50 MHz clock stands for all interface clocks.
//
// Implementation choices: the register offsets and strobed register access.
`timescale 1ns/10ps
`default_nettype none
`include "hbas_params.svh"
// Functional notes
// - Asynchronous mode keeps both FIFOs enabled
// - Internal side runs from device clock only
// - Synchronous mode bypasses both FIFOs
// - UTOPIA: flags and enables active low
// - Cascade: polarities high, data latch shifted
// - Only eight-bit data path exists
// - Address match covers transmit and receive
// - Each side samples address match separately
// - FIFO mode: transmit flags follow sampled match
// - Bypass mode: same on reference clock
// - Receive flags follow sampled match
// - Selection and reset sequence never together
// - Host asserts match before or with enable
// - Transmit addressed state enter and leave
// - Transmit flags driven only when addressed
// - Select on enable assertion while addressed (fall in UTOPIA, rise in cascade)
// - Selected: capture data each edge
// - Enable before addressing is ignored
// - Receive select drives FIFO data out
// - FIFO reset after eight held cycles
// - Bypass idle sends idle character
module hbas_dev (
  input wire logic CLOCK_I,
  input wire logic SRST_I,
  hbas_if.dev BUS,
  output logic [`HBAS_DATA_W-1:0] LINE_DATA_O,
  output logic LINE_VALID_O,
  input wire logic LINE_READY_I,
  input wire logic [`HBAS_DATA_W-1:0] LINE_DATA_I,
  input wire logic LINE_VALID_I,
  output logic TX_FIFO_RESET_O,
  output logic RX_FIFO_RESET_O
);
  localparam int D = `HBAS_FIFO_DEPTH;
  logic [`HBAS_DATA_W-1:0] tx_mem [D];
  logic [`HBAS_DATA_W-1:0] rx_mem [D];
  logic [`HBAS_PTR_W:0] tx_wp_r, tx_rp_r, rx_wp_r, rx_rp_r;
  logic am_tx_r, am_rx_r, tx_match_r, tx_rmatch_r, rx_match_r, rx_rmatch_r;
  logic tx_sel_r, rx_sel_r, transmit_write_enable_n_prev_r, receive_read_enable_n_prev_r;
  logic [3:0] tx_cnt_r, rx_cnt_r;
  logic [`HBAS_DATA_W-1:0] tx_lat_r, rx_q_r;
  logic tx_lat_v_r;
  logic cas, byp, transmit_write_enable_n, receive_read_enable_n, tx_full, tx_empty, rx_full, rx_empty;

  // Enable polarity follows timing model
  assign cas = BUS.timing_model_select;
  assign byp = ~BUS.fifo_bypass_n;
  assign transmit_write_enable_n = cas ? BUS.transmit_write_enable : ~BUS.transmit_write_enable;
  assign receive_read_enable_n = cas ? BUS.receive_read_enable : ~BUS.receive_read_enable;

  function automatic logic ptr_full(input logic [`HBAS_PTR_W:0] w, input logic [`HBAS_PTR_W:0] r);
    ptr_full = (w[`HBAS_PTR_W] != r[`HBAS_PTR_W]) &&
               (w[`HBAS_PTR_W-1:0] == r[`HBAS_PTR_W-1:0]);
  endfunction : ptr_full

  assign tx_full = ptr_full(tx_wp_r, tx_rp_r);
  assign tx_empty = (tx_wp_r == tx_rp_r);
  assign rx_full = ptr_full(rx_wp_r, rx_rp_r);
  assign rx_empty = (rx_wp_r == rx_rp_r);

  // Both sides take the same input but keep their own samples
  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      am_tx_r <= 1'b0;
      am_rx_r <= 1'b0;
    end else begin
      am_tx_r <= ~BUS.address_match_n;
      am_rx_r <= ~BUS.address_match_n;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      tx_match_r <= 1'b0;
      tx_rmatch_r <= 1'b0;
      rx_match_r <= 1'b0;
      rx_rmatch_r <= 1'b0;
    end else begin
      tx_match_r <= ~BUS.address_match_n & BUS.transmit_fifo_reset_n;
      tx_rmatch_r <= ~BUS.address_match_n & ~BUS.transmit_fifo_reset_n;
      rx_match_r <= ~BUS.address_match_n & BUS.receive_fifo_reset_n;
      rx_rmatch_r <= ~BUS.address_match_n & ~BUS.receive_fifo_reset_n;
    end
  end

  // Selection needs a fresh enable edge, so early enables never select
  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      tx_sel_r <= 1'b0;
      rx_sel_r <= 1'b0;
      transmit_write_enable_n_prev_r <= 1'b0;
      receive_read_enable_n_prev_r <= 1'b0;
    end else begin
      transmit_write_enable_n_prev_r <= transmit_write_enable_n;
      receive_read_enable_n_prev_r <= receive_read_enable_n;
      if (!transmit_write_enable_n) tx_sel_r <= 1'b0;
      else if (!transmit_write_enable_n_prev_r && tx_match_r) tx_sel_r <= 1'b1;
      if (!receive_read_enable_n) rx_sel_r <= 1'b0;
      else if (!receive_read_enable_n_prev_r && (byp ? am_rx_r : rx_match_r)) rx_sel_r <= 1'b1;
    end
  end

  // Reset sequence counts only while not selected and enable off
  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      tx_cnt_r <= 4'h0;
      rx_cnt_r <= 4'h0;
    end else begin
      if (!tx_rmatch_r) tx_cnt_r <= 4'h0;
      else if (!transmit_write_enable_n && !tx_sel_r && tx_cnt_r != `HBAS_RST_CYCLES) begin
        tx_cnt_r <= tx_cnt_r + 4'h1;
      end
      if (!rx_rmatch_r) rx_cnt_r <= 4'h0;
      else if (!receive_read_enable_n && !rx_sel_r && rx_cnt_r != `HBAS_RST_CYCLES) rx_cnt_r <= rx_cnt_r + 4'h1;
    end
  end

  wire tx_clr = tx_rmatch_r && tx_cnt_r == `HBAS_RST_CYCLES - 4'h1 && !transmit_write_enable_n;
  wire rx_clr = rx_rmatch_r && rx_cnt_r == `HBAS_RST_CYCLES - 4'h1 && !receive_read_enable_n;
  assign TX_FIFO_RESET_O = tx_clr;
  assign RX_FIFO_RESET_O = rx_clr;

  // Cascade latches the word a cycle after the enable
  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      tx_lat_r <= 8'h00;
      tx_lat_v_r <= 1'b0;
    end else begin
      tx_lat_r <= BUS.transmit_data_bus;
      tx_lat_v_r <= transmit_write_enable_n && (tx_sel_r || (!transmit_write_enable_n_prev_r && tx_match_r));
    end
  end

  wire tx_take_u = tx_sel_r && transmit_write_enable_n;
  wire tx_push = !byp && (cas ? tx_lat_v_r : tx_take_u) && !tx_full;
  wire [`HBAS_DATA_W-1:0] tx_word = cas ? tx_lat_r : BUS.transmit_data_bus;
  wire tx_pop = LINE_READY_I && !byp && !tx_empty;

  always_ff @(posedge CLOCK_I) begin
    if (SRST_I || tx_clr) begin
      tx_wp_r <= '0;
      tx_rp_r <= '0;
    end else begin
      if (tx_push) tx_wp_r <= tx_wp_r + 5'h1;
      if (tx_pop) tx_rp_r <= tx_rp_r + 5'h1;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (tx_push) tx_mem[tx_wp_r[`HBAS_PTR_W-1:0]] <= tx_word;
  end

  // Bypass: idle character whenever no data is written
  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      LINE_DATA_O <= 8'h00;
      LINE_VALID_O <= 1'b0;
    end else if (byp) begin
      LINE_DATA_O <= transmit_write_enable_n ? BUS.transmit_data_bus : `HBAS_IDLE_CHAR;
      LINE_VALID_O <= 1'b1;
    end else begin
      LINE_DATA_O <= tx_mem[tx_rp_r[`HBAS_PTR_W-1:0]];
      LINE_VALID_O <= tx_pop;
    end
  end

  wire rx_push = LINE_VALID_I && !byp && !rx_full;
  wire rx_pop = rx_sel_r && receive_read_enable_n && !byp && !rx_empty;

  always_ff @(posedge CLOCK_I) begin
    if (SRST_I || rx_clr) begin
      rx_wp_r <= '0;
      rx_rp_r <= '0;
    end else begin
      if (rx_push) rx_wp_r <= rx_wp_r + 5'h1;
      if (rx_pop) rx_rp_r <= rx_rp_r + 5'h1;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (rx_push) rx_mem[rx_wp_r[`HBAS_PTR_W-1:0]] <= LINE_DATA_I;
  end

  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) rx_q_r <= 8'h00;
    else if (byp && LINE_VALID_I) rx_q_r <= LINE_DATA_I;
    else if (rx_pop) rx_q_r <= rx_mem[rx_rp_r[`HBAS_PTR_W-1:0]];
  end

  assign BUS.receive_data_bus = rx_q_r;
  assign BUS.receive_data_oe = rx_sel_r;
  // Flags asserted show full/empty in model polarity
  assign BUS.transmit_full_flag = cas ? tx_full : ~tx_full;
  assign BUS.transmit_empty_flag = cas ? tx_empty : ~tx_empty;
  assign BUS.receive_full_flag = cas ? rx_full : ~rx_full;
  assign BUS.receive_empty_flag = cas ? rx_empty : ~rx_empty;
  assign BUS.transmit_flag_oe = byp ? am_tx_r : (tx_match_r | tx_rmatch_r);
  assign BUS.receive_flag_oe = byp ? am_rx_r : (rx_match_r | rx_rmatch_r);
endmodule : hbas_dev
`default_nettype wire

// ---- hbas_host.sv ----
// Host end: drives the bus from a small command register file.
// Assumes one clock shared with the device end.
`timescale 1ns/10ps
`default_nettype none
`include "hbas_params.svh"
module hbas_host (
  input wire logic CLOCK_I,
  input wire logic SRST_I,
  hbas_if.host BUS,
  input wire logic [3:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [7:0] RDATA_O
);
  logic [7:0] ctrl_r, txd_r, rxd_r;
  logic txgo_r, rxgo_r;
  logic cas;
  assign cas = ctrl_r[`HBAS_BIT_CAS];

  // Config bits meant to change only during reset
  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) ctrl_r <= `HBAS_CTRL_RESET;
    else if (WR_I && ADDR_I == `HBAS_REG_CTRL) ctrl_r <= WDATA_I;
  end

  // Enable levels held while go bits stand; match set first by software
  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      txgo_r <= 1'b0;
      rxgo_r <= 1'b0;
      txd_r <= 8'h00;
    end else if (WR_I && ADDR_I == `HBAS_REG_STAT) begin
      txgo_r <= WDATA_I[`HBAS_BIT_TXGO];
      rxgo_r <= WDATA_I[`HBAS_BIT_RXGO];
    end else if (WR_I && ADDR_I == `HBAS_REG_TXD) begin
      txd_r <= WDATA_I;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) rxd_r <= 8'h00;
    else if (BUS.receive_data_oe) rxd_r <= BUS.receive_data_bus;
  end

  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) RDATA_O <= 8'h00;
    else if (RD_I) begin
      case (ADDR_I)
        `HBAS_REG_CTRL: RDATA_O <= ctrl_r;
        `HBAS_REG_STAT: RDATA_O <= {BUS.receive_flag_oe, BUS.receive_full_flag,
          BUS.receive_empty_flag, BUS.transmit_flag_oe, BUS.transmit_full_flag,
          BUS.transmit_empty_flag, rxgo_r, txgo_r};
        `HBAS_REG_TXD: RDATA_O <= txd_r;
        `HBAS_REG_RXD: RDATA_O <= rxd_r;
        default: RDATA_O <= 8'h00;
      endcase
    end else RDATA_O <= 8'h00;
  end

  assign BUS.fifo_bypass_n = ctrl_r[`HBAS_BIT_BYP];
  assign BUS.timing_model_select = cas;
  assign BUS.address_match_n = ~ctrl_r[`HBAS_BIT_AM];
  assign BUS.transmit_fifo_reset_n = ~ctrl_r[`HBAS_BIT_TRANSMIT_FIFO_RESET_N];
  assign BUS.receive_fifo_reset_n = ~ctrl_r[`HBAS_BIT_RECEIVE_FIFO_RESET_N];
  assign BUS.transmit_write_enable = cas ? txgo_r : ~txgo_r;
  assign BUS.receive_read_enable = cas ? rxgo_r : ~rxgo_r;
  assign BUS.transmit_data_bus = txd_r;
endmodule : hbas_host
`default_nettype wire

// ---- hbas_monitor.sv ----
// Checker on the host bus between the two ends.
// Assumes one clock for both sides and instantiation beside the interface.
`timescale 1ns/10ps
`default_nettype none
module hbas_monitor (
  input wire logic CLOCK_I,
  input wire logic SRST_I,
  input wire logic address_match_n,
  input wire logic receive_read_enable,
  input wire logic timing_model_select,
  input wire logic transmit_full_flag,
  input wire logic transmit_empty_flag,
  input wire logic transmit_flag_oe,
  input wire logic receive_flag_oe,
  input wire logic receive_data_oe
);
  logic rx_en_act;
  logic tx_full_act;
  logic tx_empty_act;
  // Polarity follows the timing model, so judge asserted levels only
  assign rx_en_act = timing_model_select ? receive_read_enable : !receive_read_enable;
  assign tx_full_act = timing_model_select ? transmit_full_flag : !transmit_full_flag;
  assign tx_empty_act = timing_model_select ? transmit_empty_flag : !transmit_empty_flag;
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (SRST_I);
  property p_tx_oe_on; !address_match_n |=> transmit_flag_oe; endproperty
  a_tx_oe_on: assert property (p_tx_oe_on) else $error("tx flags undriven");
  property p_tx_oe_off; address_match_n |=> !transmit_flag_oe; endproperty
  a_tx_oe_off: assert property (p_tx_oe_off) else $error("tx flags driven");
  property p_rx_oe; 1'b1 |=> (receive_flag_oe == !$past(address_match_n)); endproperty
  a_rx_oe: assert property (p_rx_oe) else $error("rx flag enable wrong");
  property p_sides; transmit_flag_oe == receive_flag_oe; endproperty
  a_sides: assert property (p_sides) else $error("flag sides disagree");
  property p_flags; transmit_flag_oe |-> !(tx_full_act && tx_empty_act); endproperty
  a_flags: assert property (p_flags) else $error("full and empty both");
  property p_rx_sel; $rose(receive_data_oe) |-> $past(receive_flag_oe); endproperty
  a_rx_sel: assert property (p_rx_sel) else $error("rx select unaddressed");
  property p_rx_early; $rose(rx_en_act) && !receive_flag_oe |=> !receive_data_oe; endproperty
  a_rx_early: assert property (p_rx_early) else $error("rx early select");
  property p_rx_hold; receive_data_oe && rx_en_act |=> receive_data_oe; endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("rx select lost");
  property p_rx_drop; receive_data_oe && !rx_en_act |=> !receive_data_oe; endproperty
  a_rx_drop: assert property (p_rx_drop) else $error("rx select stuck");
endmodule : hbas_monitor
`default_nettype wire

// ---- host_bus_address_select_test.sv ----
// Bench joining device and host ends through the interface.
// Assumes host registers as handed over and one 50 MHz clock.
`timescale 1ns/10ps
`default_nettype none
`include "hbas_params.svh"
module host_bus_address_select_test;
  logic clk = 1'b0;
  logic srst = 1'b1;
  // Device end has its own reset so the host can reconfigure it
  logic dev_srst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic [7:0] rdata;
  logic [7:0] line_data_o;
  logic [7:0] line_data_i = 8'h00;
  logic line_valid_o;
  logic line_valid_i = 1'b0;
  logic tx_rst;
  logic rx_rst;
  logic [7:0] st;
  int hit;
  int error_cnt = 0;
  int tests_run = 0;
  hbas_if hbas_if_i ();
  hbas_dev hbas_dev_i (.CLOCK_I(clk), .SRST_I(dev_srst), .BUS(hbas_if_i.dev),
    .LINE_DATA_O(line_data_o), .LINE_VALID_O(line_valid_o), .LINE_READY_I(1'b1),
    .LINE_DATA_I(line_data_i), .LINE_VALID_I(line_valid_i), .TX_FIFO_RESET_O(tx_rst),
    .RX_FIFO_RESET_O(rx_rst));
  hbas_host hbas_host_i (.CLOCK_I(clk), .SRST_I(srst), .BUS(hbas_if_i.host), .ADDR_I(addr),
    .WDATA_I(wdata), .WR_I(wr_s), .RD_I(rd_s), .RDATA_O(rdata));
  hbas_monitor hbas_monitor_i (.CLOCK_I(clk), .SRST_I(dev_srst),
    .address_match_n(hbas_if_i.address_match_n),
    .receive_read_enable(hbas_if_i.receive_read_enable),
    .timing_model_select(hbas_if_i.timing_model_select),
    .transmit_full_flag(hbas_if_i.transmit_full_flag),
    .transmit_empty_flag(hbas_if_i.transmit_empty_flag),
    .transmit_flag_oe(hbas_if_i.transmit_flag_oe),
    .receive_flag_oe(hbas_if_i.receive_flag_oe),
    .receive_data_oe(hbas_if_i.receive_data_oe));
  always #10 clk = ~clk;
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    @(negedge clk);
    st = rdata;
  endtask : rd
  // First cycle within n where the watched event shows, or -1
  task automatic watch(input int n, input logic [1:0] which);
    hit = -1;
    for (int i = 0; i < n; i++) begin
      @(negedge clk);
      if (hit < 0 && (which == 2'h2 ? rx_rst : (which == 2'h1 ? tx_rst : line_valid_o)) === 1'b1)
        hit = i;
    end
  endtask : watch
  // Config only moves while the device end is in reset; match stays off
  task automatic reconfig(input logic [7:0] cfg);
    @(posedge clk);
    dev_srst <= 1'b1;
    wr(4'h0, cfg);
    tick(2);
    dev_srst <= 1'b0;
  endtask : reconfig
  task automatic t_flags();
    rd(4'h1);
    chk("flags idle", st & 8'h90, 8'h00);
    wr(4'h0, 8'h05);
    tick(2);
    rd(4'h1);
    chk("flags utopia", st & 8'hfc, 8'hd8);
    reconfig(8'h03);
    wr(4'h0, 8'h07);
    tick(2);
    rd(4'h1);
    chk("flags cascade", st & 8'hfc, 8'hb4);
    wr(4'h0, 8'h03);
    tick(2);
    rd(4'h1);
    chk("flags released", st & 8'h90, 8'h00);
    reconfig(8'h01);
  endtask : t_flags
  task automatic t_tx();
    wr(4'h2, 8'h5a);
    wr(4'h1, 8'h01);
    wr(4'h0, 8'h05);
    tick(4);
    wr(4'h1, 8'h00);
    watch(12, 2'h0);
    chk("early enable ignored", 8'(hit), 8'hff);
    wr(4'h2, 8'h3c);
    wr(4'h1, 8'h01);
    tick(4);
    wr(4'h1, 8'h00);
    @(negedge clk);
    for (int i = 0; i < 20 && line_valid_o !== 1'b1; i++) @(negedge clk);
    chk("tx byte", line_data_o, 8'h3c);
    tick(20);
  endtask : t_tx
  task automatic t_rx();
    @(posedge clk);
    line_data_i <= 8'ha7;
    line_valid_i <= 1'b1;
    @(posedge clk);
    line_valid_i <= 1'b0;
    wr(4'h1, 8'h02);
    tick(4);
    wr(4'h1, 8'h00);
    rd(4'h3);
    chk("rx byte", st, 8'ha7);
    wr(4'h0, 8'h15);
    watch(16, 2'h2);
    chk("rx reset after eight", 8'(hit >= 7 && hit <= 10), 8'h01);
    wr(4'h0, 8'h05);
  endtask : t_rx
  task automatic t_reset();
    wr(4'h0, 8'h0d);
    tick(4);
    wr(4'h0, 8'h05);
    watch(16, 2'h1);
    chk("aborted reset", 8'(hit), 8'hff);
    wr(4'h1, 8'h01);
    wr(4'h0, 8'h0d);
    watch(16, 2'h1);
    chk("reset under enable", 8'(hit), 8'hff);
    wr(4'h1, 8'h00);
    wr(4'h0, 8'h05);
    wr(4'h0, 8'h0d);
    watch(16, 2'h1);
    chk("reset after eight", 8'(hit >= 7 && hit <= 10), 8'h01);
    wr(4'h0, 8'h05);
  endtask : t_reset
  // Cascade path latches the word a cycle later but must still deliver it
  task automatic t_cascade();
    reconfig(8'h03);
    wr(4'h0, 8'h07);
    wr(4'h2, 8'h4b);
    wr(4'h1, 8'h01);
    tick(4);
    wr(4'h1, 8'h00);
    @(negedge clk);
    for (int i = 0; i < 20 && line_valid_o !== 1'b1; i++) @(negedge clk);
    chk("cascade byte", line_data_o, 8'h4b);
    tick(20);
  endtask : t_cascade
  task automatic t_bypass();
    reconfig(8'h00);
    wr(4'h0, 8'h04);
    tick(3);
    @(negedge clk);
    chk("idle char", line_data_o, `HBAS_IDLE_CHAR);
    wr(4'h2, 8'h77);
    wr(4'h1, 8'h01);
    tick(4);
    @(negedge clk);
    chk("bypass data", line_data_o, 8'h77);
    wr(4'h1, 8'h00);
  endtask : t_bypass
  task automatic tally_and_finish();
    if (error_cnt == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : tally_and_finish
  initial begin
    tick(12);
    srst <= 1'b0;
    dev_srst <= 1'b0;
    t_flags();
    t_tx();
    t_rx();
    t_reset();
    t_cascade();
    t_bypass();
    tally_and_finish();
  end
  // Whole sequence needs well under 1000 cycles
  initial begin
    #(20 * 4000);
    error_cnt++;
    tally_and_finish();
  end
endmodule : host_bus_address_select_test
`default_nettype wire
